// ---- bus_lock_io_cycle_control.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Lock output asserts on next external data access.
// - Interrupts masked after lock until release.
// - Access after unlock deasserts lock, hit or miss.
// - Lock and unlock accepted in any mode.
// - Locked accesses forced to bus despite hits.
// - Bus held locked until release access completes.
// - Trap if no release within 30 instructions.
// - Ignore repeated lock and orphan unlock.
// - Trap inside sequence sets interlock flag.
// - Lock output idles two cycles between sequences.
// - Clear accessed flag: brief lock, release, relock.
// - I/O load reads sign-extended 8/16/32 bits.
// - I/O store writes 8/16/32 bits.
// - I/O uses untranslated address, bypasses cache.
// - I/O instructions suppressed in user mode.
// - Misaligned I/O or vector load traps.
// - Vector load cycle drives indicators to zero.
// - Vector load sign-extends, untranslated, non-burst, uncached.
// - Vector load is a no-op in user mode.
// - Idle clocks between acknowledges: two plus no-ops.
module bus_lock_io_cycle_control
   import lock_io_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic              instr_valid,
   input  wire logic [2:0]        instr_op,
   input  wire logic [1:0]        instr_size,
   input  wire logic [ADDR_W-1:0] instr_addr,
   input  wire logic [DATA_W-1:0] instr_wdata,
   input  wire logic              instr_is_store,
   input  wire logic              user_mode,
   input  wire logic              cache_hit,
   input  wire logic              page_accessed,
   input  wire logic              trap_taken,
   input  wire logic              ext_irq,
   input  wire logic              bus_done,
   input  wire logic [DATA_W-1:0] bus_rdata,
   output logic                   instr_stall,
   output logic                   bus_req,
   output logic [ADDR_W-1:0]      bus_addr,
   output logic [DATA_W-1:0]      bus_wdata,
   output logic [1:0]             bus_size,
   output logic                   bus_mio,
   output logic                   bus_wr,
   output logic                   bus_dc,
   output logic                   bus_burst_ok,
   output logic                   bus_cacheable,
   output logic                   bus_lock_n,
   output logic                   interrupt_ack_cycle,
   output logic                   irq_masked,
   output logic                   cache_bypass,
   output logic                   misalign_trap,
   output logic                   window_trap,
   output logic                   io_space_load,
   output logic                   rdata_valid,
   output logic [DATA_W-1:0]      rdata,
   output logic                   interlock_flag,
   input  wire logic              interlock_clear
);

   // ---------------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------------
   function automatic logic is_misaligned(input logic [1:0] sz, input logic [1:0] a);
      case (sz)
         SIZE_HALF: is_misaligned = a[0];
         SIZE_WORD: is_misaligned = |a;
         default:   is_misaligned = 1'b0;
      endcase
   endfunction : is_misaligned

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_APEND = 3'b001,
      ST_AWAIT = 3'b010,
      ST_GAP   = 3'b011,
      ST_XFER  = 3'b100
   } bus_state_t;

   bus_state_t state;
   logic       lock_pending;
   logic       locked;
   logic       unlock_pending;
   logic       release_xfer;
   logic [5:0] instr_count;
   logic       in_sequence;
   logic       cycle_done;
   logic       ack_recent;
   logic [3:0] idle_cnt;
   logic       gap_cnt;
   logic       cur_load;
   logic       cur_vec;
   logic [1:0] cur_size;
   logic [DATA_W-1:0] ext_data;

   logic op_lock, op_unlock, op_mem, op_io, op_vec, accept, mis, need_bus, hold;

   always_comb begin
      op_lock   = instr_valid && instr_op == OP_LOCK;
      op_unlock = instr_valid && instr_op == OP_UNLOCK;
      op_mem    = instr_valid && instr_op == OP_MEM;
      op_io     = instr_valid && !user_mode &&
                  (instr_op == OP_IO_LD || instr_op == OP_IO_ST);
      op_vec    = instr_valid && !user_mode && instr_op == OP_VEC_LD;
      mis       = (op_io || op_vec) && is_misaligned(instr_size, instr_addr[1:0]);
      // Locked sequences push every data access to the bus; a finished cycle only retires.
      need_bus  = ((op_mem && (!cache_hit || lock_pending || locked)) ||
                  ((op_io || op_vec) && !mis)) && !cycle_done;
      // A vector load waits out the idle gap after the previous one.
      hold      = op_vec && ack_recent && idle_cnt != 4'h0 && !cycle_done;
      accept    = state == ST_IDLE && !hold;
   end

   assign instr_stall    = instr_valid && (!accept || need_bus);
   assign irq_masked     = in_sequence;
   assign cache_bypass   = (op_mem && (lock_pending || locked)) || op_io || op_vec;
   assign misalign_trap  = accept && mis;
   assign io_space_load  = state == ST_XFER && cur_load && !cur_vec && !bus_mio;
   assign bus_req        = state == ST_XFER || state == ST_APEND;

   // ---------------------------------------------------------------
   // Lock sequence state
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         lock_pending   <= 1'b0;
         locked         <= 1'b0;
         unlock_pending <= 1'b0;
         in_sequence    <= 1'b0;
      end else if (window_trap) begin
         lock_pending   <= 1'b0;
         locked         <= 1'b0;
         unlock_pending <= 1'b0;
         in_sequence    <= 1'b0;
      end else begin
         if (op_lock && accept && !in_sequence) begin
            lock_pending <= 1'b1;
            in_sequence  <= 1'b1;
         end
         if (op_unlock && accept && in_sequence)
            unlock_pending <= 1'b1;
         if (state == ST_XFER && bus_done && lock_pending && !unlock_pending) begin
            lock_pending <= 1'b0;
            locked       <= 1'b1;
         end
         if (state == ST_XFER && bus_done && release_xfer) begin
            locked         <= 1'b0;
            lock_pending   <= 1'b0;
            unlock_pending <= 1'b0;
            in_sequence    <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Instruction window counter
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         instr_count <= 6'h00;
         window_trap <= 1'b0;
      end else begin
         window_trap <= 1'b0;
         if (!in_sequence || window_trap)
            instr_count <= 6'h00;
         else if (instr_valid && !instr_stall && !unlock_pending) begin
            if (instr_count == LOCK_WINDOW_W)
               window_trap <= 1'b1;
            else
               instr_count <= instr_count + 6'h01;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset)
         interlock_flag <= 1'b0;
      else if ((trap_taken || window_trap || misalign_trap) && in_sequence)
         interlock_flag <= 1'b1;
      else if (interlock_clear)
         interlock_flag <= 1'b0;
   end

   // ---------------------------------------------------------------
   // Bus cycle sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state        <= ST_IDLE;
         bus_lock_n   <= 1'b1;
         gap_cnt      <= 1'b0;
         release_xfer <= 1'b0;
         cycle_done   <= 1'b0;
      end else begin
         if (instr_valid && !instr_stall)
            cycle_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (window_trap) begin
                  bus_lock_n <= 1'b1;
               end else if (accept && need_bus) begin
                  release_xfer <= op_mem && unlock_pending;
                  if (op_mem && lock_pending && !unlock_pending && !page_accessed) begin
                     bus_lock_n <= 1'b0;
                     state      <= ST_APEND;
                  end else begin
                     if (op_mem && (lock_pending || locked))
                        bus_lock_n <= 1'b0;
                     if (op_mem && unlock_pending)
                        bus_lock_n <= 1'b0;
                     state <= ST_XFER;
                  end
               end else if (accept && op_mem && unlock_pending) begin
                  bus_lock_n <= 1'b1;
               end
            end
            ST_APEND: begin
               if (bus_done) begin
                  bus_lock_n <= 1'b1;
                  gap_cnt    <= 1'b0;
                  state      <= ST_GAP;
               end
            end
            ST_GAP: begin
               gap_cnt <= 1'b1;
               if (gap_cnt) begin
                  bus_lock_n <= 1'b0;
                  state      <= ST_XFER;
               end
            end
            ST_XFER: begin
               if (bus_done) begin
                  cycle_done <= 1'b1;
                  if (release_xfer)
                     bus_lock_n <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Cycle attributes, captured when the cycle starts
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         bus_addr            <= '0;
         bus_wdata           <= '0;
         bus_size            <= SIZE_WORD;
         bus_mio             <= 1'b1;
         bus_wr              <= 1'b0;
         bus_dc              <= 1'b1;
         bus_burst_ok        <= 1'b0;
         bus_cacheable       <= 1'b0;
         interrupt_ack_cycle <= 1'b0;
         cur_load            <= 1'b0;
         cur_vec             <= 1'b0;
         cur_size            <= SIZE_WORD;
      end else if (state == ST_IDLE && accept && need_bus) begin
         bus_addr            <= instr_addr;
         bus_wdata           <= (instr_size == SIZE_BYTE) ? {24'h000000, instr_wdata[7:0]} :
                                (instr_size == SIZE_HALF) ? {16'h0000, instr_wdata[15:0]} : instr_wdata;
         bus_size            <= instr_size;
         cur_size            <= instr_size;
         cur_vec             <= op_vec;
         interrupt_ack_cycle <= op_vec;
         bus_burst_ok        <= op_mem;
         bus_cacheable       <= op_mem && !lock_pending && !locked;
         if (op_vec) begin
            bus_mio  <= ACK_MIO;
            bus_wr   <= ACK_WR;
            bus_dc   <= ACK_DC;
            cur_load <= 1'b1;
         end else if (op_io) begin
            bus_mio  <= 1'b0;
            bus_wr   <= instr_op == OP_IO_ST;
            bus_dc   <= 1'b1;
            cur_load <= instr_op == OP_IO_LD;
         end else begin
            bus_mio  <= 1'b1;
            bus_wr   <= instr_is_store;
            bus_dc   <= 1'b1;
            cur_load <= !instr_is_store;
         end
      end else if (state == ST_XFER && bus_done) begin
         interrupt_ack_cycle <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Acknowledge spacing: idle clocks after each vector load
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack_recent <= 1'b0;
         idle_cnt   <= 4'h0;
      end else if (state == ST_XFER && bus_done && cur_vec) begin
         ack_recent <= 1'b1;
         idle_cnt   <= ACK_IDLE_BASE;
      end else if (idle_cnt != 4'h0) begin
         idle_cnt <= idle_cnt - RELEASE_GAP;
      end else if (accept && op_vec) begin
         ack_recent <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Read return
   // ---------------------------------------------------------------
   size_extend u_extend (
      .size     (cur_size),
      .raw      (bus_rdata),
      .extended (ext_data)
   );

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rdata_valid <= 1'b0;
         rdata       <= '0;
      end else begin
         rdata_valid <= state == ST_XFER && bus_done && cur_load;
         if (state == ST_XFER && bus_done && cur_load)
            rdata <= ext_data;
      end
   end

endmodule : bus_lock_io_cycle_control

// ---- lock_io_pkg.sv ----
package lock_io_pkg;

   // ------------------------------------------------------------------
   // Instruction classes presented by the execution core
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_OTHER   = 3'b000,
      OP_LOCK    = 3'b001,
      OP_UNLOCK  = 3'b010,
      OP_MEM     = 3'b011,
      OP_IO_LD   = 3'b100,
      OP_IO_ST   = 3'b101,
      OP_VEC_LD  = 3'b110
   } op_class_t;

   // ------------------------------------------------------------------
   // Operand sizes
   // ------------------------------------------------------------------
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   // ------------------------------------------------------------------
   // Timing and counts
   // ------------------------------------------------------------------
   localparam int          LOCK_WINDOW      = 30;
   localparam logic [5:0]  LOCK_WINDOW_W    = 6'h1E;
   localparam logic [3:0]  ACK_IDLE_BASE    = 4'h2;
   localparam logic [3:0]  RELEASE_GAP      = 4'h1;
   localparam int          ADDR_W           = 32;
   localparam int          DATA_W           = 32;

   // Bus cycle type indicator values for an acknowledge cycle.
   localparam logic        ACK_MIO          = 1'b0;
   localparam logic        ACK_WR           = 1'b0;
   localparam logic        ACK_DC           = 1'b0;

endpackage : lock_io_pkg

// ---- size_extend.sv ----
`timescale 1ns/1ps
module size_extend
   import lock_io_pkg::*;
(
   input  wire logic [1:0]        size,
   input  wire logic [DATA_W-1:0] raw,
   output logic      [DATA_W-1:0] extended
);
   // Byte and halfword data sit in the low lanes; sign fills the rest.
   always_comb begin
      case (size)
         SIZE_BYTE: extended = {{24{raw[7]}}, raw[7:0]};
         SIZE_HALF: extended = {{16{raw[15]}}, raw[15:0]};
         default:   extended = raw;
      endcase
   end
endmodule : size_extend

// ---- bus_lock_io_props.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin checker for the lock and I/O cycle control block.
// ----------------------------------------------------------------
module bus_lock_io_props
   import lock_io_pkg::*;
(
   input wire logic              sys_clk,
   input wire logic              reset,
   input wire logic              instr_valid,
   input wire logic [2:0]        instr_op,
   input wire logic [1:0]        instr_size,
   input wire logic [ADDR_W-1:0] instr_addr,
   input wire logic              user_mode,
   input wire logic              bus_done,
   input wire logic              instr_stall,
   input wire logic              bus_req,
   input wire logic              bus_mio,
   input wire logic              bus_wr,
   input wire logic              bus_dc,
   input wire logic              bus_burst_ok,
   input wire logic              bus_cacheable,
   input wire logic              bus_lock_n,
   input wire logic              interrupt_ack_cycle,
   input wire logic              irq_masked,
   input wire logic              misalign_trap,
   input wire logic              cache_bypass,
   input wire logic              rdata_valid
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   sequence s_take(op);
      instr_valid && !instr_stall && instr_op == op;
   endsequence
   sequence s_user_take(op);
      s_take(op) ##0 user_mode;
   endsequence
   a_reset_clears_lock: assert property ($fell(reset) |-> bus_lock_n && !irq_masked && !bus_req)
      else $error("lock state not clear after reset");
   a_user_io_noop: assert property (s_user_take(OP_IO_LD) |=> !bus_req)
      else $error("user mode I/O load started a cycle");
   a_user_vec_noop: assert property (s_user_take(OP_VEC_LD) |=> !bus_req)
      else $error("user mode vector load started a cycle");
   a_ack_ind_zero: assert property (interrupt_ack_cycle && bus_req |-> !bus_mio && !bus_wr && !bus_dc)
      else $error("acknowledge cycle indicators not zero");
   a_ack_no_burst: assert property (interrupt_ack_cycle && bus_req |-> !bus_burst_ok && !bus_cacheable)
      else $error("acknowledge cycle burstable or cacheable");
   a_io_uncached: assert property (bus_req && !bus_mio |-> !bus_cacheable)
      else $error("I/O cycle marked cacheable");
   a_lock_masks_irq: assert property (!bus_lock_n |-> irq_masked)
      else $error("interrupts open while bus locked");
   a_lock_holds_cycle: assert property (!bus_lock_n && bus_req && !bus_done |=> !bus_lock_n)
      else $error("lock dropped inside a locked cycle");
   a_lock_on_bus: assert property ($fell(bus_lock_n) |-> bus_req)
      else $error("lock asserted without a bus cycle");
   a_misalign_trap: assert property (s_take(OP_IO_LD) ##0 !user_mode && instr_size == SIZE_WORD
      && instr_addr[1:0] != 2'h0 |-> ##[0:1] misalign_trap)
      else $error("misaligned I/O load did not trap");
   a_read_returns: assert property (bus_req && bus_done && !bus_wr ##1 instr_valid && !instr_stall |-> rdata_valid)
      else $error("read data not returned after cycle");
   a_io_bypass: assert property (instr_valid && !user_mode && (instr_op == OP_IO_LD || instr_op == OP_IO_ST)
      |-> cache_bypass)
      else $error("I/O access did not bypass the cache");
   a_ack_spacing: assert property (interrupt_ack_cycle && bus_req && bus_done |=> !interrupt_ack_cycle [*2])
      else $error("acknowledge cycles too close together");
endmodule : bus_lock_io_props

bind bus_lock_io_cycle_control bus_lock_io_props i_bus_lock_io_props (.sys_clk, .reset, .instr_valid,
   .instr_op, .instr_size, .instr_addr, .user_mode, .bus_done, .instr_stall, .bus_req, .bus_mio, .bus_wr,
   .bus_dc, .bus_burst_ok, .bus_cacheable, .bus_lock_n, .interrupt_ack_cycle, .irq_masked, .misalign_trap,
   .cache_bypass, .rdata_valid);

// ---- bus_partner.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// External bus, lock logic and acknowledge responder.
// ----------------------------------------------------------------
module bus_partner (
   input  wire logic        sys_clk,
   input  wire logic        reset,
   input  wire logic        bus_req,
   input  wire logic        slow,
   input  wire logic        bus_lock_n,
   input  wire logic [31:0] bus_addr,
   input  wire logic [31:0] rd_value,
   output logic             bus_done,
   output logic [31:0]      bus_rdata
);
   logic [2:0]  cnt;
   logic [31:0] lock_addr;
   logic        held;
   // Outside the done cycle the data lines toggle, so stale data cannot look valid.
   always_ff @(posedge sys_clk) begin
      if (reset || !bus_req || bus_done) begin
         cnt      <= 3'h0;
         bus_done <= 1'b0;
      end else begin
         cnt      <= cnt + 3'h1;
         bus_done <= (cnt == (slow ? 3'h4 : 3'h0));
      end
      bus_rdata <= (bus_req && !bus_done && cnt == (slow ? 3'h4 : 3'h0)) ? rd_value : ~bus_rdata;
   end
   // Only the first locked location is guarded; other masters may use the rest.
   always_ff @(posedge sys_clk) begin
      if (reset || bus_lock_n) begin
         held <= 1'b0;
      end else if (bus_req && !held) begin
         held      <= 1'b1;
         lock_addr <= bus_addr;
      end
   end
endmodule : bus_partner

// ---- bus_lock_io_cycle_control_tb_top.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Self-checking bench for the lock and I/O cycle control block.
// ----------------------------------------------------------------
module bus_lock_io_cycle_control_tb_top
   import lock_io_pkg::*;
;
   logic        sys_clk = 0, reset = 1, instr_valid = 0, instr_is_store = 0, user_mode = 0, cache_hit = 0;
   logic        page_accessed = 1, trap_taken = 0, ext_irq = 0, interlock_clear = 0, slow = 0;
   logic [2:0]  instr_op = 3'h0;
   logic [1:0]  instr_size = 2'h0;
   logic [31:0] instr_addr = 32'h0, instr_wdata = 32'h0, rd_value = 32'h0;
   wire         instr_stall, bus_req, bus_mio, bus_wr, bus_dc, bus_burst_ok, bus_cacheable, bus_lock_n;
   wire         interrupt_ack_cycle, irq_masked, cache_bypass, misalign_trap, window_trap, io_space_load;
   wire         rdata_valid, interlock_flag, bus_done;
   wire [1:0]   bus_size;
   wire [31:0]  bus_addr, bus_wdata, rdata, bus_rdata;
   int          num_errors = 0, n_checks = 0, ncyc = 0, nfell = 0, wtr = 0, mtr = 0, idle = 0, gap = 0;
   int          n0, i, u;
   logic [31:0] c_addr, c_wd, c_rd, a;
   logic        c_lock, c_ack, c_mio, c_iol, lk_prev = 1;
   logic [1:0]  c_size, sz;
   bus_lock_io_cycle_control i_bus_lock_io_cycle_control (.sys_clk, .reset, .instr_valid, .instr_op,
      .instr_size, .instr_addr, .instr_wdata, .instr_is_store, .user_mode, .cache_hit, .page_accessed,
      .trap_taken, .ext_irq, .bus_done, .bus_rdata, .instr_stall, .bus_req, .bus_addr, .bus_wdata, .bus_size,
      .bus_mio, .bus_wr, .bus_dc, .bus_burst_ok, .bus_cacheable, .bus_lock_n, .interrupt_ack_cycle,
      .irq_masked, .cache_bypass, .misalign_trap, .window_trap, .io_space_load, .rdata_valid, .rdata,
      .interlock_flag, .interlock_clear);
   bus_partner i_bus_partner (.sys_clk, .reset, .bus_req, .slow, .bus_lock_n, .bus_addr, .rd_value,
      .bus_done, .bus_rdata);
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (bus_req === 1'b1 && bus_done === 1'b1) begin
         ncyc++;
         c_addr = bus_addr;
         c_wd   = bus_wdata;
         c_lock = bus_lock_n;
         c_ack  = interrupt_ack_cycle;
         c_mio  = bus_mio;
         c_size = bus_size;
         c_iol  = io_space_load;
      end
      if (rdata_valid === 1'b1) c_rd = rdata;
      if (window_trap === 1'b1) wtr++;
      if (misalign_trap === 1'b1) mtr++;
      if (lk_prev === 1'b1 && bus_lock_n === 1'b0) nfell++;
      lk_prev = bus_lock_n;
      if (bus_req !== 1'b1) idle++;
      else if (idle > 0) begin
         gap  = idle;
         idle = 0;
      end
   end
   function automatic logic [31:0] sext(logic [1:0] s, logic [31:0] v);
      if (s == SIZE_BYTE) return {{24{v[7]}}, v[7:0]};
      if (s == SIZE_HALF) return {{16{v[15]}}, v[15:0]};
      return v;
   endfunction : sext
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Holds the instruction until the core accepts it, then lets any bus cycle finish.
   task automatic issue(logic [2:0] op, logic [1:0] sz, logic [31:0] ad, logic st, logic hit);
      int k;
      @(negedge sys_clk);
      {instr_op, instr_size, instr_addr, instr_is_store, cache_hit} = {op, sz, ad, st, hit};
      instr_wdata = $urandom;
      instr_valid = 1;
      #1;
      for (k = 0; k < 300 && instr_stall !== 1'b0; k++) @(negedge sys_clk);
      @(negedge sys_clk);
      instr_valid = 0;
      for (; k < 300 && bus_req !== 1'b0; k++) @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
      if (k >= 300) begin
         num_errors++;
         summarize();
      end
   endtask : issue
   initial begin
      void'($urandom(32'hA416));
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk) reset = 0;
      for (u = 0; u < 2; u++) begin
         user_mode = u[0];
         n0 = ncyc;
         issue(OP_LOCK, SIZE_WORD, 32'h0, 0, 0);
         issue(OP_MEM, SIZE_WORD, 32'h100, 0, 1);
         chk("locked access", 0, c_lock);
         chk("hit forced to bus", n0 + 1, ncyc);
         chk("irq masked", 1, irq_masked);
         issue(OP_UNLOCK, SIZE_WORD, 32'h0, 0, 0);
         issue(OP_MEM, SIZE_WORD, 32'h100, 1, 1);
         chk("lock released", 1, bus_lock_n);
         chk("irq unmasked", 0, irq_masked);
      end
      $display("test lock sequence done");
      user_mode = 0;
      issue(OP_UNLOCK, SIZE_WORD, 32'h0, 0, 0);
      issue(OP_MEM, SIZE_WORD, 32'h200, 0, 0);
      chk("orphan unlock", 1, c_lock);
      n0 = nfell;
      page_accessed = 0;
      issue(OP_LOCK, SIZE_WORD, 32'h0, 0, 0);
      issue(OP_LOCK, SIZE_WORD, 32'h0, 0, 0);
      issue(OP_MEM, SIZE_WORD, 32'h300, 0, 0);
      page_accessed = 1;
      chk("relock count", n0 + 2, nfell);
      issue(OP_UNLOCK, SIZE_WORD, 32'h0, 0, 0);
      issue(OP_MEM, SIZE_WORD, 32'h300, 1, 0);
      $display("test ignore and relock done");
      n0 = wtr;
      issue(OP_LOCK, SIZE_WORD, 32'h0, 0, 0);
      repeat (30) issue(OP_OTHER, SIZE_WORD, 32'h0, 0, 0);
      chk("no early trap", n0, wtr);
      issue(OP_OTHER, SIZE_WORD, 32'h0, 0, 0);
      chk("window trap", n0 + 1, wtr);
      chk("trap ends sequence", 0, irq_masked);
      issue(OP_LOCK, SIZE_WORD, 32'h0, 0, 0);
      @(negedge sys_clk) trap_taken = 1;
      @(negedge sys_clk) trap_taken = 0;
      chk("interlock flag", 1, interlock_flag);
      @(negedge sys_clk) interlock_clear = 1;
      @(negedge sys_clk) interlock_clear = 0;
      chk("flag cleared", 0, interlock_flag);
      issue(OP_UNLOCK, SIZE_WORD, 32'h0, 0, 0);
      $display("test window and trap done");
      for (i = 0; i < 6; i++) begin
         slow = i[0];
         sz = 2'(i % 3);
         rd_value = $urandom;
         a = $urandom & (32'hFFFFFFFF << sz);
         issue((i < 3) ? OP_IO_LD : OP_IO_ST, sz, a, 0, 1);
         chk("io address", a, c_addr);
         chk("io space", 0, c_mio);
         chk("io size", sz, c_size);
         chk("io load cycle", i < 3, c_iol);
         if (i < 3) chk("io load data", sext(sz, rd_value), c_rd);
         else chk("io store data", instr_wdata & ~(32'hFFFFFFFF << (8 << sz)), c_wd);
      end
      $display("test io done");
      n0 = mtr;
      i = ncyc;
      user_mode = 1;
      issue(OP_IO_LD, SIZE_WORD, 32'h40, 0, 0);
      issue(OP_VEC_LD, SIZE_WORD, 32'h40, 0, 0);
      user_mode = 0;
      issue(OP_IO_LD, SIZE_WORD, 32'h2, 0, 0);
      issue(OP_VEC_LD, SIZE_HALF, 32'h1, 0, 0);
      chk("no cycles", i, ncyc);
      chk("misalign traps", n0 + 2, mtr);
      rd_value = $urandom;
      issue(OP_VEC_LD, SIZE_BYTE, 32'h8, 0, 0);
      chk("ack cycle", 1, c_ack);
      chk("ack io", 0, c_mio);
      chk("vector data", sext(SIZE_BYTE, rd_value), c_rd);
      issue(OP_VEC_LD, SIZE_HALF, 32'h0, 0, 0);
      chk("ack gap", 1, gap >= 2);
      chk("vector half", sext(SIZE_HALF, rd_value), c_rd);
      $display("test acknowledge done");
      summarize();
   end
endmodule : bus_lock_io_cycle_control_tb_top
